// ### hw/mmuac_pkg.sv
/*
  Package for the memory management and mode control block: register map,
  field positions, reset values, address map figures and mode encodings.
  Assumes a 24-bit virtual address space and a 32-bit APB register bus.
*/
package mmuac_pkg;

  localparam logic [11:0] MMUAC_OFS_CTRL   = 12'h000;
  localparam logic [11:0] MMUAC_OFS_MODE   = 12'h004;
  localparam logic [11:0] MMUAC_OFS_TBASE  = 12'h008;
  localparam logic [11:0] MMUAC_OFS_STATUS = 12'h00c;
  localparam logic [11:0] MMUAC_OFS_PERIPH = 12'h010;
  localparam logic [11:0] MMUAC_OFS_FAULT  = 12'h014;
  localparam logic [11:0] MMUAC_OFS_SHADOW = 12'h018;

  localparam int          MMUAC_CTRL_UIRQ_BIT  = 0;
  localparam int          MMUAC_MODE_SYS_BIT   = 0;
  localparam int          MMUAC_MODE_SSYS_BIT  = 1;
  localparam logic [1:0]  MMUAC_MODE_RST       = 2'h2;
  localparam logic [23:0] MMUAC_TBASE_RST      = 24'h000000;
  localparam logic [31:0] MMUAC_DENIED_RDATA   = 32'h00000000;

  localparam logic [23:0] MMUAC_USER_ENTRY     = 24'h800000;
  localparam logic [23:0] MMUAC_SYSTEM_VECTOR_CALL_BASE      = 24'hff0000;
  localparam logic [23:0] MMUAC_SYSTEM_VECTOR_CALL_MASK      = 24'hff0000;

  localparam logic [2:0]  MMUAC_PERM_READ      = 3'h1;
  localparam logic [2:0]  MMUAC_PERM_WRITE     = 3'h2;
  localparam logic [2:0]  MMUAC_PERM_EXEC      = 3'h4;
  localparam logic [3:0]  MMUAC_CODE_END       = 4'hf;
  localparam logic [3:0]  MMUAC_CODE_LINK      = 4'he;

  localparam int          MMUAC_ENTRY_WORDS    = 4;
  localparam int          MMUAC_MAX_SEGS       = 64;
  localparam int          MMUAC_PGROUPS        = 16;

  typedef enum logic [1:0] {
    MMUAC_MD_USER,
    MMUAC_MD_SYS,
    MMUAC_MD_SSYS
  } mmuac_mode_t;

  typedef enum {
    MMUAC_SS_BOOT,
    MMUAC_SS_TEST,
    MMUAC_SS_CLESS
  } mmuac_ss_t;

endpackage : mmuac_pkg

// ### hw/mmuac_top.sv
/*
  Memory management and CPU mode control for an 8-bit secure controller.
  Assumes a CPU that issues virtual addresses with one-cycle request
  strobes and waits on mem_ack_ff; segment table words are fetched over the
  same physical memory port (4 words per entry). APB slave for setup.
*/
//Contract
//- CPU uses virtual addresses; physical goes out
//- Two partitions; only test mode reaches both
//- Partition boundaries are fixed parameters
//- User mode segments memory with rwx rights
//- System code prepares; enforced only in user
//- Entry: rights, start, end, offset, groups
//- Relocated address still partition checked
//- At most 64 segments; end/link codes
//- Table fetched from ordinary memory
//- Per-segment rights for 16 register groups
//- Full group rights outside user mode
//- Out-of-range or forbidden access raises exception
//- Denied register access ignored, constant read
//- Shadow register kept per mode group
//- Group rights follow segment; others fixed
//- Two status bits encode the mode
//- Vector call enters system; else exception
//- Exceptions set system; irq mode configurable
//- Return restores saved bits; user needs irq
//- System call to 0x800000 enters user, no push
//- Software writes to mode bits only clear
//- System mode reaches every control register
//- Boot to test or contactless; never back
module mmuac_top
  import mmuac_pkg::*;
#(
  parameter logic [23:0] NVM_BASE   = 24'h000000,
  parameter logic [23:0] NVM_SPLIT  = 24'h008000,
  parameter logic [23:0] NVM_TOP    = 24'h00ffff,
  parameter logic [23:0] ROM_BASE   = 24'h100000,
  parameter logic [23:0] ROM_SPLIT  = 24'h108000,
  parameter logic [23:0] ROM_TOP    = 24'h10ffff,
  parameter logic [23:0] RAM_BASE   = 24'h200000,
  parameter logic [23:0] RAM_TOP    = 24'h2007ff,
  parameter int          MAX_SEGS   = mmuac_pkg::MMUAC_MAX_SEGS
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        test_enable,
  input  wire logic        cpu_req,
  input  wire logic        cpu_we,
  input  wire logic        cpu_fetch,
  input  wire logic [23:0] cpu_vaddr,
  input  wire logic [7:0]  cpu_wdata,
  output logic      [7:0]  cpu_rdata_ff,
  output logic             mem_ack_ff,
  output logic             mem_req_ff,
  output logic             mem_we_ff,
  output logic      [23:0] mem_paddr_ff,
  output logic      [7:0]  mem_wdata_ff,
  input  wire logic        mem_done,
  input  wire logic [31:0] mem_rdata,
  input  wire logic        call_insn,
  input  wire logic [23:0] call_target,
  input  wire logic        irq_enter,
  input  wire logic        exc_enter,
  input  wire logic        return_from_interrupt_insn,
  input  wire logic        irq_active,
  input  wire logic        boot_done,
  output logic             exception_ff,
  output logic             no_push_ff,
  output logic      [1:0]  program_status_high_reg,
  output logic      [mmuac_pkg::MMUAC_PGROUPS-1:0] group_rights_ff
);
  import mmuac_pkg::*;

  typedef enum {ST_IDLE, ST_WALK, ST_WAIT, ST_ACCESS, ST_MEMW} mmuac_st_t;

  mmuac_st_t   st_ff;
  mmuac_ss_t   ss_ff;
  logic [1:0]  mode_ff, saved_ff;
  logic        uirq_ff;
  logic [23:0] tbase_ff, tptr_ff, seg_start_ff, seg_end_ff, seg_ofs_ff;
  logic [2:0]  seg_perm_ff;
  logic [1:0]  word_ff;
  logic [6:0]  seg_cnt_ff;
  logic        hit_valid_ff;
  logic [31:0] shadow_ff [3];
  logic [23:0] fault_ff;
  logic [MMUAC_PGROUPS-1:0] seg_groups_ff;
  logic [23:0] phys;
  logic        in_part, is_user, perm_ok, hit;
  logic [1:0]  bank;

  assign is_user = (mode_ff == 2'h0);
  assign hit = hit_valid_ff && cpu_vaddr >= seg_start_ff && cpu_vaddr <= seg_end_ff;
  assign phys = is_user ? 24'(cpu_vaddr + seg_ofs_ff) : cpu_vaddr;
  assign perm_ok = cpu_fetch ? seg_perm_ff[2] : (cpu_we ? seg_perm_ff[1] : seg_perm_ff[0]);
  assign bank = mode_ff[MMUAC_MODE_SSYS_BIT] ? 2'h2 : (mode_ff[MMUAC_MODE_SYS_BIT] ? 2'h1 : 2'h0);

  // Partition figures are parameters only: no register reaches them.
  always_comb begin
    if (ss_ff == MMUAC_SS_TEST && mode_ff[MMUAC_MODE_SSYS_BIT]) begin
      in_part = (phys >= NVM_BASE && phys <= NVM_TOP) || (phys >= ROM_BASE && phys <= ROM_TOP)
             || (phys >= RAM_BASE && phys <= RAM_TOP);
    end else begin
      in_part = (phys >= NVM_BASE && phys < NVM_SPLIT) || (phys >= ROM_BASE && phys < ROM_SPLIT)
             || (phys >= RAM_BASE && phys <= RAM_TOP);
    end
  end

  // Access sequencer; user mode walks the table on a miss.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= ST_IDLE;
      tptr_ff <= MMUAC_TBASE_RST;
      word_ff <= 2'h0;
      seg_cnt_ff <= 7'h00;
      hit_valid_ff <= 1'b0;
      seg_start_ff <= 24'h000000;
      seg_end_ff <= 24'h000000;
      seg_ofs_ff <= 24'h000000;
      seg_perm_ff <= 3'h0;
      seg_groups_ff <= '0;
      mem_req_ff <= 1'b0;
      mem_we_ff <= 1'b0;
      mem_paddr_ff <= 24'h000000;
      mem_wdata_ff <= 8'h00;
      mem_ack_ff <= 1'b0;
      cpu_rdata_ff <= 8'h00;
      exception_ff <= 1'b0;
      fault_ff <= 24'h000000;
    end else begin
      mem_ack_ff <= 1'b0;
      mem_req_ff <= 1'b0;
      exception_ff <= 1'b0;
      if (!is_user) begin
        hit_valid_ff <= 1'b0;
      end
      // Illegal vector calls and illegal user returns trap here; the mode
      // logic then enters system mode from this pulse one cycle later.
      if (call_insn && !is_user && (call_target & MMUAC_SYSTEM_VECTOR_CALL_MASK) == MMUAC_SYSTEM_VECTOR_CALL_BASE) begin
        exception_ff <= 1'b1;
      end
      if (return_from_interrupt_insn && is_user && !(uirq_ff && irq_active)) begin
        exception_ff <= 1'b1;
      end
      unique case (st_ff)
        ST_IDLE: begin
          if (cpu_req) begin
            if (is_user && !hit) begin
              st_ff <= ST_WALK;
              tptr_ff <= tbase_ff;
              word_ff <= 2'h0;
              seg_cnt_ff <= 7'h00;
            end else begin
              st_ff <= ST_ACCESS;
            end
          end
        end
        ST_WALK: begin
          mem_req_ff <= 1'b1;
          mem_we_ff <= 1'b0;
          mem_paddr_ff <= tptr_ff;
          st_ff <= ST_WAIT;
        end
        ST_WAIT: begin
          if (mem_done) begin
            tptr_ff <= tptr_ff + 24'h000004;
            word_ff <= word_ff + 2'h1;
            st_ff <= ST_WALK;
            unique case (word_ff)
              2'h0: begin
                if (mem_rdata[3:0] == MMUAC_CODE_END || seg_cnt_ff == 7'(MAX_SEGS)) begin
                  st_ff <= ST_ACCESS;
                end else if (mem_rdata[3:0] == MMUAC_CODE_LINK) begin
                  tptr_ff <= mem_rdata[31:8];
                  word_ff <= 2'h0;
                end else begin
                  seg_perm_ff <= mem_rdata[2:0];
                  seg_groups_ff <= mem_rdata[31:16];
                end
              end
              2'h1: seg_start_ff <= mem_rdata[23:0];
              2'h2: seg_end_ff <= mem_rdata[23:0];
              default: begin
                seg_ofs_ff <= mem_rdata[23:0];
                seg_cnt_ff <= seg_cnt_ff + 7'h01;
                hit_valid_ff <= 1'b1;
                word_ff <= 2'h0;
                if (cpu_vaddr >= seg_start_ff && cpu_vaddr <= seg_end_ff) begin
                  st_ff <= ST_ACCESS;
                end
              end
            endcase
          end
        end
        ST_ACCESS: begin
          if (!in_part || (is_user && (!hit || !perm_ok))) begin
            exception_ff <= 1'b1;
            fault_ff <= cpu_vaddr;
            mem_ack_ff <= 1'b1;
            cpu_rdata_ff <= 8'h00;
            st_ff <= ST_IDLE;
          end else begin
            mem_req_ff <= 1'b1;
            mem_we_ff <= cpu_we;
            mem_paddr_ff <= phys;
            mem_wdata_ff <= cpu_wdata;
            st_ff <= ST_MEMW;
          end
        end
        default: begin
          if (mem_done) begin
            mem_ack_ff <= 1'b1;
            cpu_rdata_ff <= mem_rdata[7:0];
            st_ff <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // Group rights follow the held segment in user mode, full otherwise.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      group_rights_ff <= '1;
    end else if (is_user) begin
      group_rights_ff <= hit_valid_ff ? seg_groups_ff : '0;
    end else begin
      group_rights_ff <= '1;
    end
  end

  // Super-system sub-mode: boot only after reset, leaves once for good.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ss_ff <= MMUAC_SS_BOOT;
    end else if (ss_ff == MMUAC_SS_BOOT && boot_done) begin
      ss_ff <= test_enable ? MMUAC_SS_TEST : MMUAC_SS_CLESS;
    end
  end

  logic apb_wr, mode_wr;
  assign apb_wr = psel && penable && pwrite;
  assign mode_wr = apb_wr && paddr == MMUAC_OFS_MODE;

  // Mode bits. Events outrank a software write in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_ff <= MMUAC_MODE_RST;
      saved_ff <= 2'h0;
      no_push_ff <= 1'b0;
    end else begin
      no_push_ff <= 1'b0;
      if (ss_ff == MMUAC_SS_BOOT && boot_done && !test_enable) begin
        mode_ff <= 2'h1;
      end else if (exc_enter || exception_ff) begin
        saved_ff <= mode_ff;
        mode_ff[MMUAC_MODE_SYS_BIT] <= 1'b1;
      end else if (irq_enter) begin
        saved_ff <= mode_ff;
        if (!(uirq_ff && is_user)) begin
          mode_ff[MMUAC_MODE_SYS_BIT] <= 1'b1;
        end
      end else if (call_insn && is_user
                   && (call_target & MMUAC_SYSTEM_VECTOR_CALL_MASK) == MMUAC_SYSTEM_VECTOR_CALL_BASE) begin
        saved_ff <= mode_ff;
        mode_ff[MMUAC_MODE_SYS_BIT] <= 1'b1;
      end else if (call_insn && call_target == MMUAC_USER_ENTRY && mode_ff == 2'h1) begin
        mode_ff <= 2'h0;
        no_push_ff <= 1'b1;
      end else if (return_from_interrupt_insn && (!is_user || (uirq_ff && irq_active))) begin
        mode_ff <= saved_ff;
      end else if (mode_wr) begin
        mode_ff <= mode_ff & pwdata[1:0];
      end
    end
  end

  assign program_status_high_reg = mode_ff;

  // Configuration registers: fixed policy, system or super-system only.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      uirq_ff <= 1'b0;
      tbase_ff <= MMUAC_TBASE_RST;
    end else if (apb_wr && !is_user) begin
      if (paddr == MMUAC_OFS_CTRL) begin
        uirq_ff <= pwdata[MMUAC_CTRL_UIRQ_BIT];
      end
      if (paddr == MMUAC_OFS_TBASE) begin
        tbase_ff <= pwdata[23:0];
      end
    end
  end

  // One shadow copy per mode group; each mode sees its own only.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shadow_ff[0] <= 32'h00000000;
      shadow_ff[1] <= 32'h00000000;
      shadow_ff[2] <= 32'h00000000;
    end else if (apb_wr && paddr == MMUAC_OFS_SHADOW) begin
      shadow_ff[bank] <= pwdata;
    end
  end

  // Reads of protected registers from user mode give a constant.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
      pready <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      prdata <= MMUAC_DENIED_RDATA;
      if (psel && !penable && !pwrite) begin
        unique case (paddr)
          MMUAC_OFS_CTRL: prdata <= is_user ? MMUAC_DENIED_RDATA : {31'h0, uirq_ff};
          MMUAC_OFS_MODE: prdata <= {30'h0, mode_ff};
          MMUAC_OFS_TBASE: prdata <= is_user ? MMUAC_DENIED_RDATA : {8'h0, tbase_ff};
          MMUAC_OFS_STATUS: prdata <= {23'h0, hit_valid_ff, 1'b0, seg_cnt_ff};
          MMUAC_OFS_PERIPH: prdata <= {16'h0, group_rights_ff};
          MMUAC_OFS_FAULT: prdata <= {8'h0, fault_ff};
          MMUAC_OFS_SHADOW: prdata <= shadow_ff[bank];
          default: pslverr <= 1'b0;
        endcase
      end
      if (psel && !penable && !(paddr inside {MMUAC_OFS_CTRL, MMUAC_OFS_MODE,
          MMUAC_OFS_TBASE, MMUAC_OFS_STATUS, MMUAC_OFS_PERIPH, MMUAC_OFS_FAULT,
          MMUAC_OFS_SHADOW})) begin
        pslverr <= 1'b1;
      end
    end
  end

  sequence s_walk_done;
    st_ff == ST_ACCESS;
  endsequence

  chk_full_rights_priv: assert property (@(posedge pclk) disable iff (!presetn)
    !is_user |=> group_rights_ff == '1) else $error("groups not full outside user");
  chk_mode_clear_only: assert property (@(posedge pclk) disable iff (!presetn)
    mode_wr && !exc_enter && !irq_enter && !call_insn && !return_from_interrupt_insn && !exception_ff
    && !(ss_ff == MMUAC_SS_BOOT && boot_done) |=> (mode_ff & ~$past(mode_ff)) == 2'h0)
    else $error("software write raised mode");
  chk_user_entry_call: assert property (@(posedge pclk) disable iff (!presetn)
    call_insn && call_target == MMUAC_USER_ENTRY && mode_ff == 2'h1 && !exc_enter
    && !irq_enter && !exception_ff |=> mode_ff == 2'h0 && no_push_ff)
    else $error("user entry call failed");
  chk_violation_nowrite: assert property (@(posedge pclk) disable iff (!presetn)
    exception_ff |-> !mem_req_ff) else $error("access issued on violation");
  chk_boot_no_return: assert property (@(posedge pclk) disable iff (!presetn)
    ss_ff != MMUAC_SS_BOOT |=> ss_ff != MMUAC_SS_BOOT) else $error("returned to boot");
  chk_exc_sets_sys: assert property (@(posedge pclk) disable iff (!presetn)
    exc_enter && !(ss_ff == MMUAC_SS_BOOT && boot_done) |=> mode_ff[MMUAC_MODE_SYS_BIT])
    else $error("exception did not set system bit");
  chk_walk_bounded: assert property (@(posedge pclk) disable iff (!presetn)
    seg_cnt_ff <= 7'(MAX_SEGS)) else $error("too many segments");
  chk_user_return_from_interrupt_illegal: assert property (@(posedge pclk) disable iff (!presetn)
    return_from_interrupt_insn && is_user && !uirq_ff && !exc_enter && !irq_enter && !call_insn
    && !exception_ff |=> mode_ff == 2'h0) else $error("illegal user return changed mode");
  chk_walk_reaches: assert property (@(posedge pclk) disable iff (!presetn)
    st_ff == ST_WALK |=> st_ff == ST_WAIT) else $error("table fetch not issued");
  chk_partition_exc: assert property (@(posedge pclk) disable iff (!presetn)
    s_walk_done ##0 !in_part |=> exception_ff) else $error("out of range not flagged");

endmodule : mmuac_top

// ### test/mmuac_mem_model.sv
/*
  Behavioural physical memory seen through the block's memory port.
  Assumes one request at a time; unwritten words read as a pattern of the address.
*/
module mmuac_mem_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        slow,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [23:0] mem_paddr,
  input  wire logic [7:0]  mem_wdata,
  output logic             mem_done,
  output logic      [31:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [logic [23:0]];
  logic        busy_ff;
  logic [1:0]  wait_ff;
  logic [23:0] addr_ff;

  // Table words and data share one store, so the table is ordinary memory.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_ff   <= 1'b0;
      mem_done  <= 1'b0;
      mem_rdata <= 32'h00000000;
    end else begin
      mem_done  <= 1'b0;
      // Data is only valid with the done pulse, so it is scrambled otherwise.
      mem_rdata <= ~mem_rdata;
      if (mem_req && !busy_ff) begin
        busy_ff <= 1'b1;
        wait_ff <= slow ? 2'h3 : 2'h0;
        addr_ff <= mem_paddr;
        if (mem_we) begin
          mem[mem_paddr] = {24'h000000, mem_wdata};
        end
      end else if (busy_ff && wait_ff != 2'h0) begin
        wait_ff <= wait_ff - 2'h1;
      end else if (busy_ff) begin
        busy_ff   <= 1'b0;
        mem_done  <= 1'b1;
        mem_rdata <= mem.exists(addr_ff) ? mem[addr_ff] : {8'h5a, addr_ff};
      end
    end
  end
endmodule : mmuac_mem_model

// ### test/mmuac_top_tb.sv
/*
  Self-checking bench for the memory management and mode control block.
  Assumes the default memory map parameters and a segment table placed in RAM.
*/
module mmuac_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import mmuac_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, slow;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, mem_rdata, rd;
  logic        test_enable, cpu_req, cpu_we, cpu_fetch, mem_ack_ff, mem_req_ff;
  logic        mem_we_ff, mem_done, call_insn, irq_enter, exc_enter, return_from_interrupt_insn;
  logic        irq_active, boot_done, exception_ff, no_push_ff, err, exc;
  logic [23:0] cpu_vaddr, mem_paddr_ff, call_target, last_pa;
  logic [7:0]  cpu_wdata, cpu_rdata_ff, mem_wdata_ff, rb;
  logic [1:0]  program_status_high_reg;
  logic [15:0] group_rights_ff;
  int          n_fail, comparisons, n_req, n0;

  mmuac_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .test_enable(test_enable), .cpu_req(cpu_req), .cpu_we(cpu_we),
    .cpu_fetch(cpu_fetch), .cpu_vaddr(cpu_vaddr), .cpu_wdata(cpu_wdata),
    .cpu_rdata_ff(cpu_rdata_ff), .mem_ack_ff(mem_ack_ff), .mem_req_ff(mem_req_ff),
    .mem_we_ff(mem_we_ff), .mem_paddr_ff(mem_paddr_ff), .mem_wdata_ff(mem_wdata_ff),
    .mem_done(mem_done), .mem_rdata(mem_rdata), .call_insn(call_insn),
    .call_target(call_target), .irq_enter(irq_enter), .exc_enter(exc_enter),
    .return_from_interrupt_insn(return_from_interrupt_insn), .irq_active(irq_active), .boot_done(boot_done),
    .exception_ff(exception_ff), .no_push_ff(no_push_ff),
    .program_status_high_reg(program_status_high_reg), .group_rights_ff(group_rights_ff));
  mmuac_mem_model u_mem (.pclk(pclk), .presetn(presetn), .slow(slow), .mem_req(mem_req_ff),
    .mem_we(mem_we_ff), .mem_paddr(mem_paddr_ff), .mem_wdata(mem_wdata_ff),
    .mem_done(mem_done), .mem_rdata(mem_rdata));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  always @(negedge pclk) begin
    if (mem_req_ff === 1'b1) begin
      // Table fetches are not data accesses, so they are left out of the count.
      if (mem_paddr_ff[23:9] != 15'h1000) n_req++;
      last_pa = mem_paddr_ff;
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && n++ < 50);
    if (n > 50) n_fail++;
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic acc(input logic we, input logic f, input logic [23:0] va);
    int n;
    n = 0;
    n0 = n_req;
    @(posedge pclk);
    cpu_req   <= 1'b1;
    cpu_we    <= we;
    cpu_fetch <= f;
    cpu_vaddr <= va;
    @(posedge pclk);
    cpu_req <= 1'b0;
    do @(posedge pclk); while (mem_ack_ff !== 1'b1 && n++ < 200);
    rb  = cpu_rdata_ff;
    exc = exception_ff;
    if (n > 200) n_fail++;
  endtask : acc

  // Kinds: 0 boot exit, 1 interrupt, 2 exception, 3 return, 4 call.
  task automatic ev(input int k, input logic [23:0] t);
    @(posedge pclk);
    call_target <= t;
    case (k)
      0: boot_done <= 1'b1;
      1: irq_enter <= 1'b1;
      2: exc_enter <= 1'b1;
      3: return_from_interrupt_insn <= 1'b1;
      default: call_insn <= 1'b1;
    endcase
    @(posedge pclk);
    {boot_done, irq_enter, exc_enter, return_from_interrupt_insn, call_insn} <= 5'h00;
    @(negedge pclk);
  endtask : ev

  task automatic recover();
    ev(3, 24'h0);
    chk("mode back", program_status_high_reg, 2'h0);
    ev(2, 24'h0);
    chk("mode exc", program_status_high_reg, 2'h1);
    ev(3, 24'h0);
    chk("mode return_from_interrupt", program_status_high_reg, 2'h0);
  endtask : recover

  task automatic viol(input logic we, input logic [23:0] va);
    acc(we, 1'b0, va);
    chk("viol exc", exc, 1'b1);
    chk("viol nreq", n_req - n0, 0);
    chk("viol rd", rb, 8'h00);
    recover();
  endtask : viol

  task automatic do_reset();
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
  endtask : do_reset

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : complete_run

  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    complete_run();
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata, slow, test_enable, irq_active} = '0;
    {cpu_req, cpu_we, cpu_fetch, cpu_vaddr, cpu_wdata, call_target} = '0;
    {call_insn, irq_enter, exc_enter, return_from_interrupt_insn, boot_done} = '0;
    presetn = 1'b0;
    n_req   = 0;
    u_mem.mem[24'h200000] = 32'h2001000e;
    u_mem.mem[24'h200100] = 32'h00a50007;
    u_mem.mem[24'h200104] = 32'h00000100;
    u_mem.mem[24'h200108] = 32'h000001ff;
    u_mem.mem[24'h20010c] = 32'h00000200;
    u_mem.mem[24'h200110] = 32'h5a000001;
    u_mem.mem[24'h200114] = 32'h00000400;
    u_mem.mem[24'h200118] = 32'h000004ff;
    u_mem.mem[24'h20011c] = 32'h00000000;
    u_mem.mem[24'h200120] = 32'h00000003;
    u_mem.mem[24'h200124] = 32'h00000600;
    u_mem.mem[24'h200128] = 32'h000006ff;
    u_mem.mem[24'h20012c] = 32'h00008000;
    u_mem.mem[24'h200130] = 32'h0000000f;
    do_reset();
    chk("rst mode", program_status_high_reg, 2'h2);
    chk("rst groups", group_rights_ff, 16'hffff);
    apb(1'b0, MMUAC_OFS_MODE, 32'h0);
    chk("mode reg", rd, {30'h0, MMUAC_MODE_RST});
    apb(1'b0, 12'h040, 32'h0);
    chk("unmapped", err, 1'b1);
    ev(0, 24'h0);
    chk("boot exit", program_status_high_reg, 2'h1);
    ev(0, 24'h0);
    chk("no reboot", program_status_high_reg, 2'h1);
    $display("test reset_boot done");
    acc(1'b0, 1'b0, 24'h000040);
    chk("sys pa", last_pa, 24'h000040);
    chk("sys rd", rb, 8'h40);
    cpu_wdata <= 8'h77;
    acc(1'b1, 1'b0, 24'h000050);
    acc(1'b0, 1'b0, 24'h000050);
    chk("wr back", rb, 8'h77);
    acc(1'b0, 1'b0, 24'h100020);
    chk("rom low", exc, 1'b0);
    acc(1'b0, 1'b0, 24'h300000);
    chk("range exc", exc, 1'b1);
    acc(1'b0, 1'b0, 24'h008010);
    chk("nvm hi exc", exc, 1'b1);
    acc(1'b0, 1'b0, 24'h108000);
    chk("rom hi exc", exc, 1'b1);
    ev(4, 24'hff0010);
    chk("sys vec exc", exception_ff, 1'b1);
    $display("test system_access done");
    apb(1'b1, MMUAC_OFS_TBASE, 32'h00200000);
    apb(1'b1, MMUAC_OFS_CTRL, 32'h0);
    apb(1'b1, MMUAC_OFS_SHADOW, 32'h11111111);
    ev(4, MMUAC_USER_ENTRY);
    chk("user entry", program_status_high_reg, 2'h0);
    chk("no push", no_push_ff, 1'b1);
    slow <= 1'b1;
    acc(1'b0, 1'b1, 24'h000180);
    chk("fetch pa", last_pa, 24'h000380);
    chk("fetch rd", rb, 8'h80);
    chk("groups", group_rights_ff, 16'h00a5);
    acc(1'b0, 1'b0, 24'h0001ff);
    chk("end incl", last_pa, 24'h0003ff);
    acc(1'b0, 1'b0, 24'h000420);
    chk("ro read", rb, 8'h20);
    viol(1'b0, 24'h000200);
    viol(1'b1, 24'h000410);
    viol(1'b0, 24'h000610);
    ev(3, 24'h0);
    chk("user return_from_interrupt", exception_ff, 1'b1);
    recover();
    ev(1, 24'h0);
    chk("irq sys", program_status_high_reg, 2'h1);
    ev(3, 24'h0);
    apb(1'b1, MMUAC_OFS_TBASE, 32'h00123456);
    apb(1'b0, MMUAC_OFS_TBASE, 32'h0);
    chk("denied rd", rd, MMUAC_DENIED_RDATA);
    apb(1'b1, MMUAC_OFS_SHADOW, 32'h22222222);
    apb(1'b0, MMUAC_OFS_SHADOW, 32'h0);
    chk("shadow user", rd, 32'h22222222);
    apb(1'b1, MMUAC_OFS_MODE, 32'h3);
    @(negedge pclk);
    chk("no raise", program_status_high_reg, 2'h0);
    ev(4, 24'hff0020);
    chk("user vec", program_status_high_reg, 2'h1);
    apb(1'b0, MMUAC_OFS_TBASE, 32'h0);
    chk("tbase kept", rd, 32'h00200000);
    apb(1'b0, MMUAC_OFS_SHADOW, 32'h0);
    chk("shadow sys", rd, 32'h11111111);
    chk("sys groups", group_rights_ff, 16'hffff);
    $display("test user_mode done");
    test_enable <= 1'b1;
    do_reset();
    ev(0, 24'h0);
    chk("test mode", program_status_high_reg, 2'h2);
    acc(1'b0, 1'b0, 24'h008010);
    chk("test both", exc, 1'b0);
    $display("test test_mode done");
    complete_run();
  end
endmodule : mmuac_top_tb
